// ==== rtl/swp_pkg.sv ====
// package for the sector write protection block: map, fields, timing
package swp_pkg;

  localparam int unsigned NUM_SECTORS   = 32;
  localparam int unsigned SEC_W         = 5;
  localparam int unsigned PWD_W         = 64;
  localparam int unsigned CLK_MHZ       = 100;

  // timing, in microseconds, and derived cycle counts
  localparam int unsigned UNLOCK_GAP_US    = 100;
  localparam int unsigned UNLOCK_GAP_CYC   = UNLOCK_GAP_US * CLK_MHZ;
  localparam int unsigned PAGE_PROG_US     = 340;
  localparam int unsigned PAGE_PROG_CYC    = PAGE_PROG_US * CLK_MHZ;
  localparam int unsigned SECTOR_ERASE_US  = 5200;
  localparam int unsigned SECTOR_ERASE_CYC = SECTOR_ERASE_US * CLK_MHZ;
  localparam int unsigned CNT_W            = 20;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CFG    = 8'h0c;
  localparam logic [7:0] OFS_NVLOCK = 8'h10;
  localparam logic [7:0] OFS_VLOCK  = 8'h14;
  localparam logic [7:0] OFS_PWD_LO = 8'h18;
  localparam logic [7:0] OFS_PWD_HI = 8'h1c;
  localparam logic [7:0] OFS_QUERY  = 8'h20;

  // ctrl register fields
  localparam int unsigned CTRL_SWD_BIT = 0;
  localparam int unsigned CTRL_BP_LSB  = 1;
  localparam int unsigned CTRL_TB_BIT  = 4;

  // status register fields
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_ERR_BIT   = 1;
  localparam int unsigned ST_GUARD_BIT = 2;
  localparam int unsigned ST_PWMODE_BIT = 3;

  // protection config register mode field at [2:1]
  localparam int unsigned CFG_MODE_LSB   = 1;
  localparam logic [1:0]  MODE_DEFAULT   = 2'h3;
  localparam logic [1:0]  MODE_PERSIST   = 2'h2;
  localparam logic [1:0]  MODE_PASSWORD  = 2'h1;
  localparam logic [1:0]  MODE_ILLEGAL   = 2'h0;
  localparam logic [31:0] CFG_RESET      = 32'h0000_0006;

  // command codes written to the command register
  typedef enum logic [3:0] {
    CMD_NONE      = 4'h0,
    CMD_NV_PROG   = 4'h1,
    CMD_NV_ERASE  = 4'h2,
    CMD_V_WRITE   = 4'h3,
    CMD_GUARD_CLR = 4'h4,
    CMD_UNLOCK    = 4'h5,
    CMD_CFG_PROG  = 4'h6,
    CMD_PWD_PROG  = 4'h7
  } swp_cmd_t;

  localparam int unsigned CMD_SEC_LSB = 8;
  localparam int unsigned CMD_VAL_BIT = 16;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_PREP   = 3'b001,
    ST_ERASE  = 3'b010,
    ST_PROG   = 3'b011,
    ST_WAIT   = 3'b100
  } swp_state_t;

  typedef struct packed {
    logic        paddr_ok;
    logic        wr;
    logic        rd;
  } swp_acc_t;

endpackage : swp_pkg

// ==== rtl/swp_sector_protect.sv ====
// sector write protection: lock bits, guard bit, mode selection, apb registers
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module swp_sector_protect
  import swp_pkg::*;
#(
  parameter int unsigned PROG_CYC  = PAGE_PROG_CYC,
  parameter int unsigned ERASE_CYC = SECTOR_ERASE_CYC,
  parameter int unsigned GAP_CYC   = UNLOCK_GAP_CYC
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic                   power_on_reset,
  input  wire logic                   soft_reset,
  input  wire logic                   write_protect_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic [31:0]                 prdata,
  output logic [NUM_SECTORS-1:0]      sector_protected_q,
  output logic                        operation_pending_flag_q
);

  // nonvolatile storage: no reset at all
  logic [NUM_SECTORS-1:0] nonvolatile_sector_lock_q;
  logic [PWD_W-1:0]       password_q;
  logic [31:0]            protection_config_register_q;
  logic                   nv_init_q = 1'b0;

  logic [NUM_SECTORS-1:0] volatile_sector_lock_q;
  logic                   lock_guard_register_q;
  logic [31:0]            ctrl_q;
  logic [PWD_W-1:0]       supplied_pwd_q;
  logic                   err_q;
  logic                   wp_meta_q;
  logic                   wp_sync_q;
  logic [CNT_W-1:0]       cnt_q;
  logic                   pwd_match;
  logic                   cmd_wr;
  logic                   nv_step;
  logic                   op_start;
  logic                   op_refused;
  logic [31:0]            status_word;
  logic [NUM_SECTORS-1:0] bp_mask;
  swp_state_t             state_q;
  swp_cmd_t               op_q;
  logic [SEC_W-1:0]       op_sec_q;
  logic [31:0]            op_data_q;
  swp_acc_t               acc;
  swp_cmd_t               cmd;
  logic                   busy;
  logic                   guard_pw_mode;
  logic                   cfg_locked;
  logic                   reg_write_block;

  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = CNT_W'(n);
  endfunction : cyc

  function automatic logic [1:0] mode_field(input logic [31:0] w);
    mode_field = w[CFG_MODE_LSB +: 2];
  endfunction : mode_field

  // block protection mask from 3-bit field and top/bottom select
  function automatic logic [NUM_SECTORS-1:0] bp_decode(input logic [2:0] bp, input logic tb);
    logic [NUM_SECTORS-1:0] m;
    int unsigned            n;
    m = '0;
    n = (bp == 3'h0) ? 0 : (1 << (bp - 3'h1)) * NUM_SECTORS / 64;
    if (bp != 3'h0 && n == 0) begin
      n = 1;
    end
    for (int i = 0; i < NUM_SECTORS; i++) begin
      if (tb) begin
        m[i] = (i < n);
      end else begin
        m[i] = (i >= NUM_SECTORS - n);
      end
    end
    bp_decode = m;
  endfunction : bp_decode

  assign acc.paddr_ok = (paddr[1:0] == 2'h0) && (paddr <= OFS_QUERY);
  assign acc.wr       = psel && penable && pwrite && pready;
  assign acc.rd       = psel && penable && !pwrite;
  assign cmd          = swp_cmd_t'(pwdata[3:0]);
  assign busy         = (state_q != ST_IDLE);
  assign guard_pw_mode = (mode_field(protection_config_register_q) == MODE_PASSWORD);
  assign cfg_locked   = (mode_field(protection_config_register_q) != MODE_DEFAULT);
  assign pwd_match    = (supplied_pwd_q == password_q);
  assign cmd_wr       = acc.wr && (paddr == OFS_CMD);
  assign nv_step      = busy && (cnt_q == '0) && !err_q;
  assign reg_write_block = !wp_sync_q && ctrl_q[CTRL_SWD_BIT];
  assign bp_mask      = bp_decode(ctrl_q[CTRL_BP_LSB +: 3], ctrl_q[CTRL_TB_BIT]);

  // write-protect pin synchroniser
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wp_meta_q <= 1'b1;
      wp_sync_q <= 1'b1;
    end else begin
      wp_meta_q <= write_protect_n;
      wp_sync_q <= wp_meta_q;
    end
  end

  // apb handshake: one wait state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && penable && !pready && !acc.paddr_ok;
    end
  end

  // status word assembled from named field positions
  always_comb begin
    status_word                = 32'h0000_0000;
    status_word[ST_BUSY_BIT]   = busy;
    status_word[ST_ERR_BIT]    = err_q;
    status_word[ST_GUARD_BIT]  = lock_guard_register_q;
    status_word[ST_PWMODE_BIT] = guard_pw_mode;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (acc.rd && !pready) begin
      case (paddr)
        OFS_CTRL:   prdata <= ctrl_q;
        OFS_STATUS: prdata <= status_word;
        OFS_CFG:    prdata <= protection_config_register_q;
        OFS_NVLOCK: prdata <= nonvolatile_sector_lock_q;
        OFS_VLOCK:  prdata <= volatile_sector_lock_q;
        OFS_PWD_LO: prdata <= guard_pw_mode ? 32'h0 : password_q[31:0];
        OFS_PWD_HI: prdata <= guard_pw_mode ? 32'h0 : password_q[63:32];
        default:    prdata <= 32'h0000_0000;
      endcase
    end
  end

  // status/config register: guarded by pin and write-disable
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q <= 32'h0000_0000;
    end else if (acc.wr && paddr == OFS_CTRL && !reg_write_block && !busy) begin
      ctrl_q <= {27'h0, pwdata[4:0]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      supplied_pwd_q <= '0;
    end else if (acc.wr && paddr == OFS_PWD_LO) begin
      supplied_pwd_q[31:0] <= pwdata;
    end else if (acc.wr && paddr == OFS_PWD_HI) begin
      supplied_pwd_q[63:32] <= pwdata;
    end
  end

  // volatile locks: unprotected after any reset, freely written
  always_ff @(posedge clk_sys) begin
    if (reset || soft_reset || power_on_reset) begin
      volatile_sector_lock_q <= '1;
    end else if (acc.wr && paddr == OFS_CMD && cmd == CMD_V_WRITE && !busy) begin
      volatile_sector_lock_q[pwdata[CMD_SEC_LSB +: SEC_W]] <= pwdata[CMD_VAL_BIT];
    end
  end

  // guard bit: soft reset does not touch it
  always_ff @(posedge clk_sys) begin
    if (reset || power_on_reset) begin
      lock_guard_register_q <= !guard_pw_mode;
    end else if (acc.wr && paddr == OFS_CMD && cmd == CMD_GUARD_CLR && !busy) begin
      lock_guard_register_q <= 1'b0;
    end else if (state_q == ST_WAIT && op_q == CMD_UNLOCK && pwd_match && guard_pw_mode) begin
      lock_guard_register_q <= 1'b1;
    end
  end

  // commands that run through the sequencer
  always_comb begin
    op_start = 1'b0;
    if (cmd_wr && state_q == ST_IDLE) begin
      case (cmd)
        CMD_NV_PROG, CMD_NV_ERASE, CMD_UNLOCK, CMD_CFG_PROG, CMD_PWD_PROG: op_start = 1'b1;
        default: op_start = 1'b0;
      endcase
    end
  end

  // refused or failing commands, judged as the command arrives
  always_comb begin
    op_refused = 1'b0;
    case (cmd)
      CMD_NV_PROG, CMD_NV_ERASE: op_refused = !lock_guard_register_q;
      CMD_CFG_PROG: op_refused = cfg_locked || reg_write_block
                    || (mode_field(pwdata >> CMD_SEC_LSB) == MODE_ILLEGAL);
      CMD_PWD_PROG: op_refused = cfg_locked;
      default:      op_refused = 1'b0;
    endcase
  end

  // command sequencer
  always_ff @(posedge clk_sys) begin
    if (reset || power_on_reset) begin
      state_q   <= ST_IDLE;
      op_q      <= CMD_NONE;
      op_sec_q  <= '0;
      op_data_q <= 32'h0000_0000;
      cnt_q     <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (op_start) begin
            op_q      <= cmd;
            op_sec_q  <= pwdata[CMD_SEC_LSB +: SEC_W];
            op_data_q <= pwdata;
            cnt_q     <= (cmd == CMD_UNLOCK) ? cyc(GAP_CYC) : cyc(PROG_CYC);
            state_q   <= (cmd == CMD_NV_ERASE) ? ST_PREP : ST_WAIT;
          end
        end
        ST_PREP: begin
          if (cnt_q == '0) begin
            cnt_q   <= cyc(ERASE_CYC);
            state_q <= ST_ERASE;
          end else begin
            cnt_q <= cnt_q - cyc(1);
          end
        end
        ST_ERASE, ST_WAIT: begin
          if (cnt_q == '0 || (op_q == CMD_UNLOCK && pwd_match)) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - cyc(1);
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // error flag: set on refused or failed operations, cleared by new command
  always_ff @(posedge clk_sys) begin
    if (reset || power_on_reset) begin
      err_q <= 1'b0;
    end else if (state_q == ST_IDLE && cmd_wr) begin
      err_q <= op_refused;
    end else if (state_q == ST_WAIT && op_q == CMD_UNLOCK && cnt_q == '0 && !pwd_match) begin
      err_q <= 1'b1;
    end
  end

  // nonvolatile storage comes up once, at the first clock
  always_ff @(posedge clk_sys) begin
    nv_init_q <= 1'b1;
  end

  // nonvolatile locks: kept through every reset
  always_ff @(posedge clk_sys) begin
    if (!nv_init_q) begin
      nonvolatile_sector_lock_q <= '1;
    end else if (nv_step) begin
      case (state_q)
        ST_PREP:  nonvolatile_sector_lock_q <= '0;
        ST_ERASE: nonvolatile_sector_lock_q <= '1;
        ST_WAIT: begin
          if (op_q == CMD_NV_PROG && lock_guard_register_q) begin
            nonvolatile_sector_lock_q[op_sec_q] <= 1'b0;
          end
        end
        default: nonvolatile_sector_lock_q <= nonvolatile_sector_lock_q;
      endcase
    end
  end

  // password: programs zeros only, closed once a mode is chosen
  always_ff @(posedge clk_sys) begin
    if (!nv_init_q) begin
      password_q <= '1;
    end else if (nv_step && state_q == ST_WAIT && op_q == CMD_PWD_PROG && !cfg_locked) begin
      password_q <= password_q & supplied_pwd_q;
    end
  end

  // protection config: one-time mode bits
  always_ff @(posedge clk_sys) begin
    if (!nv_init_q) begin
      protection_config_register_q <= CFG_RESET;
    end else if (nv_step && state_q == ST_WAIT && op_q == CMD_CFG_PROG && !cfg_locked) begin
      protection_config_register_q[CFG_MODE_LSB +: 2] <=
        mode_field(op_data_q >> CMD_SEC_LSB);
    end
  end

  // sector verdict and busy flag
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sector_protected_q <= '1;
    end else begin
      sector_protected_q <= bp_mask | ~nonvolatile_sector_lock_q | ~volatile_sector_lock_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      operation_pending_flag_q <= 1'b0;
    end else begin
      operation_pending_flag_q <= busy;
    end
  end

endmodule : swp_sector_protect

// ==== verif/swp_host_model.sv ====
// host side model: apb master that polls the busy flag
`timescale 1ns/1ps
module swp_host_model
  import swp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= ~w;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer

  task automatic wait_idle();
    logic [31:0] r;
    logic        e;
    r = 32'h1;
    while (r[ST_BUSY_BIT] !== 1'b0) begin
      xfer(1'b0, OFS_STATUS, 32'h0, r, e);
    end
  endtask : wait_idle
endmodule : swp_host_model

// ==== verif/swp_sector_protect_properties.sv ====
// port checker for the sector write protection block
`timescale 1ns/1ps
module swp_sector_protect_properties
  import swp_pkg::*;
(
  input wire logic                   clk_sys,
  input wire logic                   reset,
  input wire logic                   power_on_reset,
  input wire logic                   write_protect_n,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic [31:0]            prdata,
  input wire logic [NUM_SECTORS-1:0] sector_protected_q,
  input wire logic                   operation_pending_flag_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset || power_on_reset);

  pready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after one wait state");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  pready_phase_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  slverr_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  addr_error_a: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > OFS_QUERY))
    else $error("pslverr does not match address");
  reset_prot_a: assert property ($fell(reset) |-> sector_protected_q == '1)
    else $error("sectors not protected during reset");
  query_zero_a: assert property (pready && !pwrite && paddr == OFS_QUERY |-> prdata == 32'h0)
    else $error("query register not zero");
  block_all_a: assert property (pready && pwrite && paddr == OFS_CTRL && pwdata[3:1] == 3'h7
    && write_protect_n && $past(write_protect_n, 3) && !operation_pending_flag_q
    |-> ##[1:3] sector_protected_q == '1)
    else $error("full block protect not applied");
  nv_busy_a: assert property (pready && pwrite && paddr == OFS_CMD &&
    !operation_pending_flag_q && pwdata[3:0] inside {CMD_NV_PROG, CMD_NV_ERASE}
    |-> ##[1:3] operation_pending_flag_q)
    else $error("lock operation not busy");

  cover property (pready && pslverr);
  cover property (sector_protected_q == '1);
  cover property (pready && pwrite && paddr == OFS_CMD && pwdata[3:0] == CMD_UNLOCK);
endmodule : swp_sector_protect_properties

bind swp_sector_protect swp_sector_protect_properties i_props (
  .clk_sys(clk_sys), .reset(reset), .power_on_reset(power_on_reset),
  .write_protect_n(write_protect_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .sector_protected_q(sector_protected_q),
  .operation_pending_flag_q(operation_pending_flag_q)
);

// ==== verif/swp_sector_protect_tb.sv ====
// self-checking bench for the sector write protection block
`timescale 1ns/1ps
module swp_sector_protect_tb;
  import swp_pkg::*;
  localparam int unsigned P = 20;
  localparam int unsigned G = 200;
  localparam logic [63:0] PWD = 64'h0123_4567_89ab_cdef;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        power_on_reset = 1'b0;
  logic        soft_reset = 1'b0;
  logic        write_protect_n = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, busy, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, prot, r;
  time         t0;
  int          bad_count = 0;
  int          checked = 0;

  always #5 clk_sys = ~clk_sys;

  swp_sector_protect #(.PROG_CYC(P), .ERASE_CYC(2 * P), .GAP_CYC(G)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .power_on_reset(power_on_reset),
    .soft_reset(soft_reset), .write_protect_n(write_protect_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .sector_protected_q(prot), .operation_pending_flag_q(busy));

  swp_host_model i_host (
    .clk_sys(clk_sys), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    i_host.xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic cmd(input swp_cmd_t c, input logic [4:0] s, input logic v);
    wr(OFS_CMD, {15'h0, v, 3'h0, s, 4'h0, c});
    i_host.wait_idle();
    repeat (4) @(posedge clk_sys);
  endtask : cmd

  task automatic t_fresh();
    rd(OFS_STATUS, 32'h4);
    rd(OFS_CFG, CFG_RESET);
    rd(OFS_NVLOCK, '1);
    chk(prot, 32'h0);
    rd(OFS_QUERY, 32'h0);
    i_host.xfer(1'b0, 8'h24, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
  endtask : t_fresh

  task automatic t_locks();
    cmd(CMD_V_WRITE, 5'd3, 1'b0);
    chk(prot, 32'h8);
    cmd(CMD_V_WRITE, 5'd3, 1'b1);
    chk(prot, 32'h0);
    cmd(CMD_NV_PROG, 5'd5, 1'b0);
    rd(OFS_NVLOCK, ~32'h20);
    chk(prot, 32'h20);
    wr(OFS_CMD, {28'h0, CMD_NV_ERASE});
    repeat (2) @(posedge clk_sys);
    chk({31'h0, busy}, 32'h1);
    i_host.wait_idle();
    rd(OFS_NVLOCK, '1);
    wr(OFS_CTRL, 32'he);
    repeat (4) @(posedge clk_sys);
    chk(prot, '1);
    wr(OFS_CTRL, 32'h0);
  endtask : t_locks

  task automatic t_pin();
    wr(OFS_CTRL, 32'h1);
    write_protect_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wr(OFS_CTRL, 32'he);
    rd(OFS_CTRL, 32'h1);
    chk(prot, 32'h0);
    write_protect_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_CTRL, 32'h0);
  endtask : t_pin

  task automatic t_guard();
    cmd(CMD_V_WRITE, 5'd7, 1'b0);
    cmd(CMD_GUARD_CLR, 5'd0, 1'b0);
    rd(OFS_STATUS, 32'h0);
    wr(OFS_PWD_LO, 32'hffff_ffff);
    wr(OFS_PWD_HI, 32'hffff_ffff);
    cmd(CMD_UNLOCK, 5'd0, 1'b0);
    rd(OFS_STATUS, 32'h0);
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
    rd(OFS_STATUS, 32'h0);
    rd(OFS_VLOCK, '1);
    cmd(CMD_NV_PROG, 5'd2, 1'b0);
    rd(OFS_STATUS, 32'h2);
    rd(OFS_NVLOCK, '1);
    cmd(CMD_V_WRITE, 5'd7, 1'b0);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rd(OFS_STATUS, 32'h4);
    rd(OFS_VLOCK, '1);
  endtask : t_guard

  task automatic t_password();
    wr(OFS_PWD_LO, PWD[31:0]);
    wr(OFS_PWD_HI, PWD[63:32]);
    cmd(CMD_PWD_PROG, 5'd0, 1'b0);
    cmd(CMD_CFG_PROG, {2'b0, MODE_ILLEGAL, 1'b0}, 1'b0);
    rd(OFS_STATUS, 32'h6);
    rd(OFS_CFG, CFG_RESET);
    cmd(CMD_CFG_PROG, {2'b0, MODE_PASSWORD, 1'b0}, 1'b0);
    rd(OFS_CFG, 32'h2);
    cmd(CMD_CFG_PROG, {2'b0, MODE_PERSIST, 1'b0}, 1'b0);
    rd(OFS_CFG, 32'h2);
    cmd(CMD_V_WRITE, 5'd0, 1'b1);
    power_on_reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    power_on_reset <= 1'b0;
    rd(OFS_STATUS, 32'h8);
    rd(OFS_PWD_HI, 32'h0);
    wr(OFS_PWD_LO, ~PWD[31:0]);
    t0 = $time;
    cmd(CMD_UNLOCK, 5'd0, 1'b0);
    chk({31'h0, ($time - t0) >= G * 10}, 32'h1);
    rd(OFS_STATUS, 32'ha);
    wr(OFS_PWD_LO, PWD[31:0]);
    t0 = $time;
    cmd(CMD_UNLOCK, 5'd0, 1'b0);
    chk({31'h0, ($time - t0) < G * 5}, 32'h1);
    rd(OFS_STATUS, 32'hc);
  endtask : t_password

  task automatic final_report();
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    t_fresh();
    t_locks();
    t_pin();
    t_guard();
    t_password();
    final_report();
  end

  initial begin
    #500000;
    bad_count++;
    final_report();
  end
endmodule : swp_sector_protect_tb
